// [include/repeater_cfg_defs.svh]
// Register offsets, field positions, reset values and codes of the
// repeater configuration bank. Included by the package and the bank.
`ifndef REPEATER_CFG_DEFS_SVH
`define REPEATER_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SOFT_RESET_CTRL       8'h00
`define OFS_LANE_SHUTDOWN_MASK    8'h01
`define OFS_SHUTDOWN_PIN_OVERRIDE 8'h02
`define OFS_PIN_CONTROL_OVERRIDE  8'h08
`define OFS_SQUELCH_SPEED_SELECT  8'h0e
`define OFS_CH0_RX_BOOST          8'h0f
`define OFS_CH0_TX_SWING          8'h10
`define OFS_CH0_TX_EMPHASIS       8'h11
`define OFS_CH0_SQUELCH_LEVEL     8'h12
`define OFS_STATUS_ROUTE          8'h4c
`define OFS_STATUS_PIN_MODE       8'h4e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_SOFT_RESET            0
`define BIT_BLOCK_SHUTDOWN_PIN    0
`define BIT_BLOCK_IDLE_PIN        4
`define BIT_BLOCK_RATE_PIN        2
`define BIT_IDLE_AUTO             5
`define BIT_IDLE_SELECT           4
`define BIT_RATE_AUTO             1
`define BIT_RATE_SELECT           0
`define BIT_STATUS_PINS_OUT       0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_LANE_SHUTDOWN_MASK    8'h00
`define RST_CH0_RX_BOOST          6'h20
`define RST_CH0_TX_SWING          6'h03
`define RST_CH0_TX_EMPHASIS       8'h03
`define RST_CH0_SQUELCH_LEVEL     4'h0
`define RST_STATUS_ROUTE          2'h0
`define TX_EMPHASIS_RESERVED      8'hc0
`define STATUS_ROUTE_RATE         2'h3
`define SMB_ADDR_BASE             3'h5

`endif

// [include/repeater_cfg_pkg.sv]
// Types shared by the repeater configuration bank.
// Assumes the constants header sits on the include path.
`include "repeater_cfg_defs.svh"

package repeater_cfg_pkg;

  // ----------------------------------------------------------------
  // Management serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
    ST_WDATA, ST_ACK_WR, ST_RDATA, ST_RACK, ST_RLOAD
  } smb_state_type;

  // ----------------------------------------------------------------
  // Stored configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lane_mask;
    logic       block_shutdown_pin;
    logic       block_idle_pin;
    logic       block_rate_pin;
    logic       idle_auto;
    logic       idle_select;
    logic       rate_auto;
    logic       rate_select;
    logic [5:0] rx_boost;
    logic [5:0] tx_swing;
    logic [7:0] tx_emphasis;
    logic [3:0] squelch_level;
    logic [1:0] status_route;
    logic       status_pins_out;
  } cfg_type;

endpackage : repeater_cfg_pkg

// [design/pin_sync.sv]
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bit-to-bit coherence is given.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  always_comb begin
    d        = q;
    d.stage1 = i_async;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.stage2;

endmodule : pin_sync

`default_nettype wire

// [design/repeater_lane_config_regs.sv]
// Configuration register bank of a multi-lane repeater with its
// management serial slave, pin overrides and rate status pins.
// Assumes open-drain resolution of the data line and pull-ups outside.
//
// Notes on behaviour
// R1: Soft reset bit restores every register default
// R2: Mask bits power down individual lanes
// R3: Override bit zero lets power-down pin rule
// R4: Idle override bit blocks idle pin
// R5: Rate override bit blocks rate pin
// R6: Idle auto bit chooses automatic idle detect
// R7: Manual idle: one mutes, zero keeps output
// R8: Rate auto or forced low/high range
// R9: Boost field: enable, gain stage, boost step
// R10: Boost resets to bypass code
// R11: Swing field codes, default lowest swing
// R12: Emphasis type bit and level field
// R13: Reserved emphasis code is never stored
// R14: Squelch de-assert and assert level codes
// R15: Host writes route code for rate status
// R16: Status pin high means high rate
// R17: Serial access only with enable pin high
// R18: Pin mode bit makes status pins outputs
// R19: Host writes reserved bits as zero
`timescale 1ns/10ps
`default_nettype none
`include "repeater_cfg_defs.svh"

module repeater_lane_config_regs (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_serial_config_enable,
  input  wire logic [1:0] i_addr_lo,
  input  wire logic       i_power_down_pin,
  input  wire logic       i_idle_pin,
  input  wire logic       i_rate_pin,
  input  wire logic [7:0] i_rate_detect,
  input  wire logic [3:0] i_gpio,
  output logic      [3:0] o_gpio,
  output logic      [3:0] o_gpio_oe,
  output logic      [7:0] o_lane_shutdown,
  output logic            o_power_down,
  output logic            o_idle_auto,
  output logic            o_idle_mute,
  output logic            o_rate_auto,
  output logic            o_rate_high,
  output logic            o_rx_boost_enable,
  output logic      [1:0] o_gain_stage,
  output logic      [2:0] o_boost_step,
  output logic      [5:0] o_tx_swing,
  output logic            o_tx_emphasis_type,
  output logic      [6:0] o_tx_emphasis_level,
  output logic      [1:0] o_squelch_deassert,
  output logic      [1:0] o_squelch_assert
);
  import repeater_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    smb_state_type fsm;
    logic [2:0]    bcnt;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          rw;
    logic          drive;
    logic          scl_prev;
    logic          sda_prev;
    cfg_type       cfg;
    logic          power_down;
    logic          idle_auto;
    logic          idle_mute;
    logic          rate_auto;
    logic          rate_high;
    logic [3:0]    gpio;
  } bank_state_type;

  localparam cfg_type CFG_DEFAULT = '{
    lane_mask:          `RST_LANE_SHUTDOWN_MASK,
    block_shutdown_pin: 1'b0,
    block_idle_pin:     1'b0,
    block_rate_pin:     1'b0,
    idle_auto:          1'b0,
    idle_select:        1'b0,
    rate_auto:          1'b0,
    rate_select:        1'b0,
    rx_boost:           `RST_CH0_RX_BOOST,
    tx_swing:           `RST_CH0_TX_SWING,
    tx_emphasis:        `RST_CH0_TX_EMPHASIS,
    squelch_level:      `RST_CH0_SQUELCH_LEVEL,
    status_route:       `RST_STATUS_ROUTE,
    status_pins_out:    1'b0
  };

  bank_state_type q;
  bank_state_type d;

  logic [17:0] async_in;
  logic [17:0] sync_out;
  logic        scl_s;
  logic        sda_s;
  logic        pd_pin_s;
  logic        idle_pin_s;
  logic        rate_pin_s;
  logic        enable_s;
  logic [1:0]  addr_lo_s;
  logic [1:0]  addr_hi_s;
  logic [7:0]  rate_s;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  byte_in;
  logic [6:0]  dev_addr;
  logic        scl_rise;
  logic        scl_fall;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign async_in = {i_rate_detect, i_gpio[3:2], i_addr_lo, i_serial_config_enable,
                     i_rate_pin, i_idle_pin, i_power_down_pin, i_sda, i_scl};

  pin_sync #(
    .WIDTH (18)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (async_in),
    .o_sync  (sync_out)
  );

  assign {rate_s, addr_hi_s, addr_lo_s, enable_s, rate_pin_s, idle_pin_s,
          pd_pin_s, sda_s, scl_s} = sync_out;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    case (q.ptr)
      `OFS_LANE_SHUTDOWN_MASK:    rd_data = q.cfg.lane_mask;
      `OFS_SHUTDOWN_PIN_OVERRIDE: rd_data = {7'h00, q.cfg.block_shutdown_pin};
      `OFS_PIN_CONTROL_OVERRIDE:  rd_data = {3'h0, q.cfg.block_idle_pin, 1'b0,
                                             q.cfg.block_rate_pin, 2'h0};
      `OFS_SQUELCH_SPEED_SELECT:  rd_data = {2'h0, q.cfg.idle_auto, q.cfg.idle_select, 2'h0,
                                             q.cfg.rate_auto, q.cfg.rate_select};
      `OFS_CH0_RX_BOOST:          rd_data = {2'h0, q.cfg.rx_boost};
      `OFS_CH0_TX_SWING:          rd_data = {2'h0, q.cfg.tx_swing};
      `OFS_CH0_TX_EMPHASIS:       rd_data = q.cfg.tx_emphasis;
      `OFS_CH0_SQUELCH_LEVEL:     rd_data = {4'h0, q.cfg.squelch_level};
      `OFS_STATUS_ROUTE:          rd_data = {q.cfg.status_route, 6'h00};
      `OFS_STATUS_PIN_MODE:       rd_data = {7'h00, q.cfg.status_pins_out};
      default:                    rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial slave, register writes and output control
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    wr_en    = 1'b0;
    wr_addr  = q.ptr;
    byte_in  = {q.shreg[6:0], sda_s};
    wr_data  = byte_in;
    scl_rise = scl_s & ~q.scl_prev;
    scl_fall = ~scl_s & q.scl_prev;
    dev_addr = {`SMB_ADDR_BASE, (q.cfg.status_pins_out ? 2'h0 : addr_hi_s), addr_lo_s}; // R18
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;

    if (!enable_s) begin
      d.fsm   = ST_IDLE; // R17
      d.drive = 1'b0; // R17
    end else if (scl_s && q.scl_prev && q.sda_prev && !sda_s) begin
      d.fsm   = ST_ADDR;
      d.bcnt  = 3'h0;
      d.drive = 1'b0;
    end else if (scl_s && q.scl_prev && !q.sda_prev && sda_s) begin
      d.fsm   = ST_IDLE;
      d.drive = 1'b0;
    end else if (scl_rise) begin
      case (q.fsm)
        ST_ADDR: begin
          d.shreg = byte_in;
          d.bcnt  = q.bcnt + 3'h1;
          if (q.bcnt == 3'h7) begin
            if (byte_in[7:1] == dev_addr) begin
              d.rw  = byte_in[0];
              d.fsm = ST_ACK_ADDR;
            end else begin
              d.fsm = ST_IDLE;
            end
          end
        end
        ST_REG: begin
          d.shreg = byte_in;
          d.bcnt  = q.bcnt + 3'h1;
          if (q.bcnt == 3'h7) begin
            d.ptr = byte_in;
            d.fsm = ST_ACK_REG;
          end
        end
        ST_WDATA: begin
          d.shreg = byte_in;
          d.bcnt  = q.bcnt + 3'h1;
          if (q.bcnt == 3'h7) begin
            wr_en = 1'b1;
            d.fsm = ST_ACK_WR;
          end
        end
        ST_RDATA: begin
          d.bcnt = q.bcnt + 3'h1;
          if (q.bcnt == 3'h7) begin
            d.fsm = ST_RACK;
          end
        end
        ST_RACK: begin
          if (!sda_s) begin
            d.ptr = q.ptr + 8'h01;
            d.fsm = ST_RLOAD;
          end else begin
            d.fsm = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q.fsm)
        ST_ACK_ADDR: begin
          if (!q.drive) begin
            d.drive = 1'b1;
          end else if (q.rw) begin
            d.shreg = rd_data;
            d.drive = ~rd_data[7];
            d.bcnt  = 3'h0;
            d.fsm   = ST_RDATA;
          end else begin
            d.drive = 1'b0;
            d.bcnt  = 3'h0;
            d.fsm   = ST_REG;
          end
        end
        ST_ACK_REG: begin
          d.drive = ~q.drive;
          if (q.drive) begin
            d.bcnt = 3'h0;
            d.fsm  = ST_WDATA;
          end
        end
        ST_ACK_WR: begin
          d.drive = ~q.drive;
          if (q.drive) begin
            d.bcnt = 3'h0;
            d.ptr  = q.ptr + 8'h01;
            d.fsm  = ST_WDATA;
          end
        end
        ST_RDATA: begin
          d.shreg = {q.shreg[6:0], 1'b0};
          d.drive = ~q.shreg[6];
        end
        ST_RACK: begin
          d.drive = 1'b0;
        end
        ST_RLOAD: begin
          d.shreg = rd_data;
          d.drive = ~rd_data[7];
          d.bcnt  = 3'h0;
          d.fsm   = ST_RDATA;
        end
        default: begin
        end
      endcase
    end

    if (wr_en) begin
      case (wr_addr)
        `OFS_SOFT_RESET_CTRL: begin
          if (wr_data[`BIT_SOFT_RESET]) begin
            d.cfg = CFG_DEFAULT; // R1 R10 R11
          end
        end
        `OFS_LANE_SHUTDOWN_MASK:    d.cfg.lane_mask = wr_data; // R2
        `OFS_SHUTDOWN_PIN_OVERRIDE: d.cfg.block_shutdown_pin = wr_data[`BIT_BLOCK_SHUTDOWN_PIN];
        `OFS_PIN_CONTROL_OVERRIDE: begin
          d.cfg.block_idle_pin = wr_data[`BIT_BLOCK_IDLE_PIN];
          d.cfg.block_rate_pin = wr_data[`BIT_BLOCK_RATE_PIN];
        end
        `OFS_SQUELCH_SPEED_SELECT: begin
          d.cfg.idle_auto   = wr_data[`BIT_IDLE_AUTO];
          d.cfg.idle_select = wr_data[`BIT_IDLE_SELECT];
          d.cfg.rate_auto   = wr_data[`BIT_RATE_AUTO];
          d.cfg.rate_select = wr_data[`BIT_RATE_SELECT];
        end
        `OFS_CH0_RX_BOOST:       d.cfg.rx_boost = wr_data[5:0]; // R9
        `OFS_CH0_TX_SWING:       d.cfg.tx_swing = wr_data[5:0]; // R11
        `OFS_CH0_TX_EMPHASIS: begin
          if (wr_data != `TX_EMPHASIS_RESERVED) begin
            d.cfg.tx_emphasis = wr_data; // R12 R13
          end
        end
        `OFS_CH0_SQUELCH_LEVEL:  d.cfg.squelch_level = wr_data[3:0]; // R14
        `OFS_STATUS_ROUTE:       d.cfg.status_route = wr_data[7:6];
        `OFS_STATUS_PIN_MODE:    d.cfg.status_pins_out = wr_data[`BIT_STATUS_PINS_OUT];
        default: begin
        end
      endcase
    end

    d.power_down = ~q.cfg.block_shutdown_pin & pd_pin_s; // R3
    if (q.cfg.block_idle_pin) begin
      d.idle_auto = q.cfg.idle_auto; // R6
      d.idle_mute = ~q.cfg.idle_auto & q.cfg.idle_select; // R7
    end else begin
      d.idle_auto = 1'b0; // R4
      d.idle_mute = idle_pin_s; // R4
    end
    if (q.cfg.block_rate_pin) begin
      d.rate_auto = q.cfg.rate_auto; // R8
      d.rate_high = ~q.cfg.rate_auto & q.cfg.rate_select; // R8
    end else begin
      d.rate_auto = 1'b0; // R5
      d.rate_high = rate_pin_s; // R5
    end
    if (q.cfg.status_route == `STATUS_ROUTE_RATE) begin
      d.gpio = {rate_s[5] | rate_s[7], rate_s[4] | rate_s[6],
                rate_s[1] | rate_s[3], rate_s[0] | rate_s[2]}; // R15 R16
    end else begin
      d.gpio = 4'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q     <= '0;
      q.fsm <= ST_IDLE;
      q.cfg <= CFG_DEFAULT;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sda               = 1'b0;
  assign o_sda_oe            = q.drive;
  assign o_gpio              = q.gpio;
  assign o_gpio_oe           = {4{q.cfg.status_pins_out}}; // R18
  assign o_lane_shutdown     = q.cfg.lane_mask;
  assign o_power_down        = q.power_down;
  assign o_idle_auto         = q.idle_auto;
  assign o_idle_mute         = q.idle_mute;
  assign o_rate_auto         = q.rate_auto;
  assign o_rate_high         = q.rate_high;
  assign o_rx_boost_enable   = q.cfg.rx_boost[5];
  assign o_gain_stage        = q.cfg.rx_boost[4:3];
  assign o_boost_step        = q.cfg.rx_boost[2:0];
  assign o_tx_swing          = q.cfg.tx_swing;
  assign o_tx_emphasis_type  = q.cfg.tx_emphasis[7];
  assign o_tx_emphasis_level = q.cfg.tx_emphasis[6:0];
  assign o_squelch_deassert  = q.cfg.squelch_level[3:2];
  assign o_squelch_assert    = q.cfg.squelch_level[1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_soft_reset_defaults: assert property ( // R1
    wr_en && wr_addr == `OFS_SOFT_RESET_CTRL && wr_data[0] |=>
      o_lane_shutdown == 8'h00 && {o_rx_boost_enable, o_gain_stage, o_boost_step} == 6'h20
      && o_tx_swing == 6'h03 && q.cfg.tx_emphasis == 8'h03)
    else $error("soft reset left a register off its default");
  a_lane_mask_write: assert property ( // R2
    wr_en && wr_addr == `OFS_LANE_SHUTDOWN_MASK |=> o_lane_shutdown == $past(wr_data))
    else $error("lane mask not taken");
  a_pd_pin_rules: assert property ( // R3
    ##1 o_power_down == ($past(pd_pin_s) && !$past(q.cfg.block_shutdown_pin)))
    else $error("power-down output wrong for pin and override");
  a_idle_pin_follow: assert property ( // R4
    !q.cfg.block_idle_pin |=> o_idle_mute == $past(idle_pin_s) && !o_idle_auto)
    else $error("idle pin not followed");
  a_rate_pin_follow: assert property ( // R5
    !q.cfg.block_rate_pin |=> o_rate_high == $past(rate_pin_s) && !o_rate_auto)
    else $error("rate pin not followed");
  a_idle_auto_mode: assert property ( // R6
    q.cfg.block_idle_pin && q.cfg.idle_auto |=> o_idle_auto && !o_idle_mute)
    else $error("automatic idle not selected");
  a_idle_manual_mute: assert property ( // R7
    q.cfg.block_idle_pin && !q.cfg.idle_auto |=> o_idle_mute == $past(q.cfg.idle_select))
    else $error("manual idle select ignored");
  a_rate_forced_range: assert property ( // R8
    q.cfg.block_rate_pin && !q.cfg.rate_auto |=> !o_rate_auto
      && o_rate_high == $past(q.cfg.rate_select))
    else $error("forced rate range wrong");
  a_boost_fields: assert property ( // R9
    wr_en && wr_addr == `OFS_CH0_RX_BOOST |=>
      {o_rx_boost_enable, o_gain_stage, o_boost_step} == $past(wr_data[5:0]))
    else $error("boost fields not taken");
  a_emph_reserved_kept: assert property ( // R13
    wr_en && wr_addr == `OFS_CH0_TX_EMPHASIS && wr_data == 8'hc0 |=>
      $stable(q.cfg.tx_emphasis))
    else $error("reserved emphasis code stored");
  a_emph_fields: assert property ( // R12
    wr_en && wr_addr == `OFS_CH0_TX_EMPHASIS && wr_data != 8'hc0 |=>
      {o_tx_emphasis_type, o_tx_emphasis_level} == $past(wr_data))
    else $error("emphasis fields not taken");
  a_squelch_fields: assert property ( // R14
    wr_en && wr_addr == `OFS_CH0_SQUELCH_LEVEL |=>
      {o_squelch_deassert, o_squelch_assert} == $past(wr_data[3:0]))
    else $error("squelch levels not taken");
  a_rate_status_pins: assert property ( // R16
    q.cfg.status_route == 2'h3 |=> o_gpio[0] == ($past(rate_s[0]) | $past(rate_s[2]))
      && o_gpio[3] == ($past(rate_s[5]) | $past(rate_s[7])))
    else $error("rate status pins wrong");
  a_disabled_is_silent: assert property ( // R17
    !enable_s |=> !o_sda_oe && q.fsm == ST_IDLE)
    else $error("serial slave active while disabled");

endmodule : repeater_lane_config_regs

`default_nettype wire

// [sim/smb_host_model.sv]
// Serial management host driving clock and data of the config bank.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none

module smb_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda
);
  logic [6:0] dev;
  logic       nak;
  logic       s;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    dev = 7'h59;
    nak = 1'b0;
  end

  task automatic ph();
    repeat (8) @(negedge i_mclk);
  endtask : ph

  task automatic bio(input logic b, output logic v);
    o_sda = b;
    ph();
    o_scl = 1'b1;
    ph();
    v = i_sda;
    o_scl = 1'b0;
    ph();
  endtask : bio

  task automatic start();
    o_sda = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b0;
    ph();
  endtask : start

  task automatic stop();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b1;
    ph();
  endtask : stop

  task automatic ob(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bio(b[i], s);
    bio(1'b1, s);
    nak = nak | s;
  endtask : ob

  // Host stores data bytes whole, reserved bits left to the caller
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    nak = 1'b0;
    start();
    ob({dev, 1'b0});
    ob(r);
    ob(d);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    nak = 1'b0;
    start();
    ob({dev, 1'b0});
    ob(r);
    start();
    ob({dev, 1'b1});
    for (int i = 7; i >= 0; i--) bio(1'b1, d[i]);
    bio(1'b1, s);
    stop();
  endtask : rd
endmodule : smb_host_model
`default_nettype wire

// [sim/repeater_lane_config_regs_test.sv]
// Self-checking bench of the repeater configuration bank.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
`default_nettype none

module repeater_lane_config_regs_test;
  logic mclk, rst_n, scl, hsda, sda, sda_o, sda_oe, en, pd_pin, idle_pin, rate_pin;
  logic ia, im, ra, rh, pd, be, et;
  logic [1:0] alo, gs, sqd, sa;
  logic [2:0] bs;
  logic [3:0] gpio, gpio_oe, gpio_in, gext;
  logic [5:0] sw;
  logic [6:0] el;
  logic [7:0] rdet, mask;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] bc [8] = '{8'h2a, 8'h30, 8'h31, 8'h38, 8'h34, 8'h35, 8'h3a, 8'h3c};
  logic [7:0] sc [5] = '{8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h03};
  logic [7:0] ec [5] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'ha0};

  assign sda = hsda & (sda_o | ~sda_oe);
  assign gpio_in = (gpio & gpio_oe) | (gext & ~gpio_oe);

  smb_host_model h (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));

  repeater_lane_config_regs DUT (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
    .o_sda_oe(sda_oe), .i_serial_config_enable(en), .i_addr_lo(alo),
    .i_power_down_pin(pd_pin), .i_idle_pin(idle_pin), .i_rate_pin(rate_pin),
    .i_rate_detect(rdet), .i_gpio(gpio_in), .o_gpio(gpio), .o_gpio_oe(gpio_oe),
    .o_lane_shutdown(mask), .o_power_down(pd), .o_idle_auto(ia), .o_idle_mute(im),
    .o_rate_auto(ra), .o_rate_high(rh), .o_rx_boost_enable(be), .o_gain_stage(gs),
    .o_boost_step(bs), .o_tx_swing(sw), .o_tx_emphasis_type(et),
    .o_tx_emphasis_level(el), .o_squelch_deassert(sqd), .o_squelch_assert(sa)
  );

  function automatic logic [1:0] ctl(input logic o, a, s, p);
    return o ? {a, ~a & s} : {1'b0, p};
  endfunction : ctl

  function automatic logic [3:0] gmap(input logic [7:0] r);
    return {r[5] | r[7], r[4] | r[6], r[1] | r[3], r[0] | r[2]};
  endfunction : gmap

  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cfg_def();
    chk("mask", mask, 8'h00);
    chk("boost", 8'({be, gs, bs}), 8'h20);
    chk("swing", 8'(sw), 8'h03);
    chk("emph", {et, el}, 8'h03);
    chk("squelch", 8'({sqd, sa}), 8'h00);
    chk("gpio oe", 8'(gpio_oe), 8'h00);
  endtask : cfg_def

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d, v, o;
    {rst_n, en, alo, pd_pin, idle_pin, rate_pin, rdet, gext} = {1'b0, 1'b1, 2'h1, 11'h0, 4'h8};
    void'($urandom(88880));
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    cfg_def();
    h.rd(8'h11, d);
    chk("emph read", d, 8'h03);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'($urandom()) : 8'h00;
      h.wr(8'h01, v);
      chk("mask", mask, v);
      h.rd(8'h01, d);
      chk("mask read", d, v);
    end
    pd_pin = 1'b1;
    repeat (4) @(negedge mclk);
    chk("pd pin", 8'(pd), 8'h01);
    h.wr(8'h02, 8'h01);
    chk("pd block", 8'(pd), 8'h00);
    h.wr(8'h02, 8'h00);
    chk("pd allow", 8'(pd), 8'h01);
    pd_pin = 1'b0;
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom()) & 8'h33;
      o = 8'($urandom()) & 8'h14;
      {idle_pin, rate_pin} = 2'($urandom());
      h.wr(8'h08, o);
      h.wr(8'h0e, v);
      chk("idle", 8'({ia, im}), 8'(ctl(o[4], v[5], v[4], idle_pin)));
      chk("rate", 8'({ra, rh}), 8'(ctl(o[2], v[1], v[0], rate_pin)));
    end
    foreach (bc[i]) begin
      h.wr(8'h0f, bc[i]);
      chk("boost", 8'({be, gs, bs}), bc[i]);
    end
    foreach (sc[i]) begin
      h.wr(8'h10, sc[i]);
      chk("swing", 8'(sw), sc[i]);
    end
    foreach (ec[i]) begin
      h.wr(8'h11, ec[i]);
      chk("emph", {et, el}, ec[i]);
    end
    h.wr(8'h11, 8'hc0);
    chk("emph kept", {et, el}, 8'ha0);
    chk("gpio off", 8'(gpio), 8'h00);
    rdet = 8'($urandom());
    h.wr(8'h4c, 8'hc0);
    chk("gpio", 8'(gpio), 8'(gmap(rdet)));
    h.wr(8'h4e, 8'h01);
    h.dev = 7'h51;
    chk("gpio oe", 8'(gpio_oe), 8'h0f);
    rdet = 8'($urandom());
    repeat (4) @(negedge mclk);
    chk("gpio", 8'(gpio), 8'(gmap(rdet)));
    v = 8'($urandom()) & 8'h0f;
    h.wr(8'h12, v);
    chk("new addr ack", 8'(h.nak), 8'h00);
    chk("squelch", 8'({sqd, sa}), v);
    en = 1'b0;
    repeat (4) @(negedge mclk);
    h.wr(8'h01, 8'h5a);
    chk("disabled nak", 8'(h.nak), 8'h01);
    chk("mask kept", mask, 8'h00);
    en = 1'b1;
    repeat (4) @(negedge mclk);
    h.wr(8'h01, 8'h3c);
    h.wr(8'h00, 8'h01);
    h.dev = 7'h59;
    cfg_def();
    chk("gpio reset", 8'(gpio), 8'h00);
    report_and_stop();
  end
endmodule : repeater_lane_config_regs_test
`default_nettype wire
